// ### dv/timer_measure_event_count_tb_top.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
module timer_measure_event_count_tb_top;
   logic        clk;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        gate_input_n;
   logic        counter_clock_input;
   logic        timer_output;
   logic        timer_output_oe;
   logic        irq;
   logic [15:0] v;
   int          n_fail;
   int          samples_checked;

   tmec_timer tmec_timer_inst (
      .clk                 (clk),
      .rstn                (rstn),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .gate_input_n        (gate_input_n),
      .counter_clock_input (counter_clock_input),
      .timer_output        (timer_output),
      .timer_output_oe     (timer_output_oe),
      .irq                 (irq)
   );
   tmec_src tmec_src_inst (
      .clk                 (clk),
      .gate_input_n        (gate_input_n),
      .counter_clock_input (counter_clock_input)
   );

   always #4 clk = ~clk;

   // ----
   // bus and compare tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] m,
                       input logic [15:0] e);
      rd(a, v);
      chk(v & m, e);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #100us;
      n_fail++;
      end_of_test();
   end

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      // reset values, read-only count, unmapped place, forced levels
      rchk(8'h00, 16'hffff, 16'h0000);
      rchk(8'h04, 16'hffff, 16'h08ff);
      wr(8'h08, 16'h1234);
      rchk(8'h08, 16'hffff, 16'h0000);
      rchk(8'h10, 16'hffff, 16'h0000);
      for (int i = 2; i < 4; i++) begin
         wr(8'h00, 16'(i));
         // pin level lags the control write by two register stages
         repeat (3) @(posedge clk);
         chk({timer_output_oe, timer_output}, 16'(2 | (i & 1)));
      end
      rchk(8'h04, 16'h0200, 16'h0200);
      // pulse width: four falls while asserted, later gate ignored
      wr(8'h0c, 16'hfffd);
      wr(8'h00, 16'h8b11);
      rchk(8'h04, 16'h0400, 16'h0000);
      tmec_src_inst.gate(1);
      rchk(8'h04, 16'h0c00, 16'h0400);
      tmec_src_inst.falls(4);
      tmec_src_inst.gate(0);
      rchk(8'h04, 16'h7d00, 16'h3900);
      rd(8'h08, v);
      chk(~v + 16'h0001, 16'h0004);
      tmec_src_inst.gate(1);
      tmec_src_inst.falls(2);
      tmec_src_inst.gate(0);
      rchk(8'h08, 16'hffff, 16'hfffc);
      wr(8'h04, 16'h0000);
      rchk(8'h04, 16'h2000, 16'h2000);
      wr(8'h00, 16'hab11);
      repeat (3) @(posedge clk);
      chk(irq, 16'h0001);
      wr(8'h04, 16'h2000);
      rchk(8'h04, 16'h2000, 16'h0000);
      repeat (3) @(posedge clk);
      chk(irq, 16'h0000);
      // period: first negation ignored, second assertion stops
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h7000);
      wr(8'h00, 16'h8b15);
      tmec_src_inst.gate(1);
      tmec_src_inst.falls(2);
      tmec_src_inst.gate(0);
      rchk(8'h04, 16'h2400, 16'h0400);
      tmec_src_inst.falls(2);
      tmec_src_inst.gate(1);
      rchk(8'h04, 16'h2400, 16'h2000);
      tmec_src_inst.gate(0);
      tmec_src_inst.falls(1);
      tmec_src_inst.gate(1);
      rchk(8'h08, 16'hffff, 16'hfffc);
      // events with the gate disabled: gate has no effect
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h7000);
      wr(8'h00, 16'h8319);
      tmec_src_inst.gate(0);
      tmec_src_inst.falls(3);
      tmec_src_inst.gate(1);
      tmec_src_inst.gate(0);
      rchk(8'h08, 16'hffff, 16'hfffd);
      rchk(8'h04, 16'h2400, 16'h0400);
      // events with the gate enabled: pause and resume from held value
      wr(8'h00, 16'h0000);
      wr(8'h00, 16'h8b19);
      tmec_src_inst.gate(1);
      tmec_src_inst.falls(2);
      tmec_src_inst.gate(0);
      rchk(8'h04, 16'h2400, 16'h2000);
      tmec_src_inst.falls(2);
      rchk(8'h08, 16'hffff, 16'hfffe);
      tmec_src_inst.gate(1);
      tmec_src_inst.falls(1);
      rchk(8'h08, 16'hffff, 16'hfffd);
      rchk(8'h04, 16'h0400, 16'h0400);
      wr(8'h00, 16'h0000);
      repeat (3) @(posedge clk);
      chk(timer_output_oe, 16'h0000);
      end_of_test();
   end
endmodule // timer_measure_event_count_tb_top

// ### dv/tmec_chk.sv
// port checker for the timer channel
`timescale 1ns/1ps
module tmec_chk (
   // clock and reset
   input wire        clk,
   input wire        rstn,
   // register port
   input wire [7:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   // pins and request
   input wire        gate_input_n,
   input wire        counter_clock_input,
   input wire        timer_output,
   input wire        timer_output_oe,
   input wire        irq
);
   // ----
   // shadow of control and compare, age counters
   // ----
   logic [15:0] ctl_q;
   logic [15:0] cmp_q;
   logic [3:0]  gst_q;
   logic [3:0]  age_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl_q <= 16'h0000;
         cmp_q <= 16'h0000;
         gst_q <= 4'h0;
         age_q <= 4'hf;
      end else begin
         if (reg_wr && reg_addr == 8'h00) ctl_q <= reg_wdata;
         if (reg_wr && reg_addr == 8'h0c) cmp_q <= reg_wdata;
         if ($changed(gate_input_n)) gst_q <= 4'h0;
         else if (gst_q != 4'hf) gst_q <= gst_q + 4'h1;
         // output may only move after an input fall or a write
         if ($fell(counter_clock_input) || reg_wr) age_q <= 4'h0;
         else if (age_q != 4'hf) age_q <= age_q + 4'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----
   // assertions
   // ----
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > 8'h0c
      |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   ctl_back_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
      |-> (reg_rdata & 16'hfbff) == ($past(ctl_q) & 16'hfbff))
      else $error("control read back differs");
   cmp_back_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0c
      |-> reg_rdata == $past(cmp_q)) else $error("compare read back differs");
   oe_off_a: assert property (ctl_q[1:0] == 2'h0
      && $past(ctl_q[1:0], 2) == 2'h0
      |-> !timer_output_oe) else $error("output driven while off");
   out_low_a: assert property (ctl_q[1:0] == 2'h2
      && $past(ctl_q[1:0], 2) == 2'h2
      |-> timer_output_oe && !timer_output) else $error("output not low");
   out_high_a: assert property (ctl_q[1:0] == 2'h3
      && $past(ctl_q[1:0], 2) == 2'h3
      |-> timer_output_oe && timer_output) else $error("output not high");
   irq_masked_a: assert property (ctl_q[14:12] == 3'h0
      && $past(ctl_q[14:12], 2) == 3'h0 |-> !irq) else $error("masked request");
   gate_level_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h04
      && gst_q > 4'h5 |-> reg_rdata[11] == gate_input_n)
      else $error("gate level bit differs from pin");
   out_cause_a: assert property ($changed(timer_output) && ctl_q[8]
      && $past(ctl_q[8]) |-> age_q < 4'h9) else $error("output moved uncaused");
   cover property ($past(reg_rd) && $past(reg_addr) == 8'h04 && reg_rdata[13]);
   cover property ($rose(irq));
   cover property (timer_output_oe && timer_output);
endmodule // tmec_chk

bind tmec_timer tmec_chk tmec_chk_inst (
   .clk                 (clk),
   .rstn                (rstn),
   .reg_addr            (reg_addr),
   .reg_wdata           (reg_wdata),
   .reg_wr              (reg_wr),
   .reg_rd              (reg_rd),
   .reg_rdata           (reg_rdata),
   .gate_input_n        (gate_input_n),
   .counter_clock_input (counter_clock_input),
   .timer_output        (timer_output),
   .timer_output_oe     (timer_output_oe),
   .irq                 (irq)
);

// ### dv/tmec_src.sv
// gate and counter clock source facing the timer pins
`timescale 1ns/1ps
module tmec_src (
   // clock
   input  wire  clk,
   // pins toward the timer
   output logic gate_input_n,
   output logic counter_clock_input
);
   // clock rests high between bursts, gate rests negated
   initial begin
      gate_input_n = 1'b1;
      counter_clock_input = 1'b1;
   end
   // gate is asserted low; wait out synchroniser and flag latency
   task automatic gate(input logic on);
      @(posedge clk);
      gate_input_n <= !on;
      repeat (8) @(posedge clk);
   endtask
   // each phase held 4 clk so no fall is lost in the synchroniser
   task automatic falls(input int n);
      repeat (n) begin
         @(posedge clk);
         counter_clock_input <= 1'b0;
         repeat (4) @(posedge clk);
         counter_clock_input <= 1'b1;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
endmodule // tmec_src

// ### rtl/tmec_map.vh
// register map, field positions, reset values and codes of the timer channel
`ifndef TMEC_MAP_VH
`define TMEC_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TMEC_OFS_CONTROL   8'h00
`define TMEC_OFS_STATUS    8'h04
`define TMEC_OFS_COUNT     8'h08
`define TMEC_OFS_COMPARE   8'h0c

// ----------------------------------------------------------------------
// control_word fields
// ----------------------------------------------------------------------
`define TMEC_CW_RUN        15
`define TMEC_CW_IE_HI      14
`define TMEC_CW_IE_LO      12
`define TMEC_CW_GATE_EN    11
`define TMEC_CW_CPE        9
`define TMEC_CW_EXT_CLK    8
`define TMEC_CW_TAP_HI     7
`define TMEC_CW_TAP_LO     5
`define TMEC_CW_MODE_HI    4
`define TMEC_CW_MODE_LO    2
`define TMEC_CW_OC_HI      1
`define TMEC_CW_OC_LO      0

// ----------------------------------------------------------------------
// status_word fields
// ----------------------------------------------------------------------
`define TMEC_SW_IRQ        15
`define TMEC_SW_TIMEOUT    14
`define TMEC_SW_GATE_EVT   13
`define TMEC_SW_COMPARE    12
`define TMEC_SW_GATE_LVL   11
`define TMEC_SW_RUNNING    10
`define TMEC_SW_OUT_LVL    9
`define TMEC_SW_CMP_STATE  8

// ----------------------------------------------------------------------
// interrupt_select bit positions inside the 3-bit field
// ----------------------------------------------------------------------
`define TMEC_IE_COMPARE    0
`define TMEC_IE_GATE       1
`define TMEC_IE_TIMEOUT    2

// ----------------------------------------------------------------------
// mode_select and output_control codes
// ----------------------------------------------------------------------
`define TMEC_MODE_PULSE    3'h4
`define TMEC_MODE_PERIOD   3'h5
`define TMEC_MODE_EVENT    3'h6
`define TMEC_OC_OFF        2'h0
`define TMEC_OC_TOGGLE     2'h1
`define TMEC_OC_LOW        2'h2
`define TMEC_OC_HIGH       2'h3

// ----------------------------------------------------------------------
// reset values and load constants
// ----------------------------------------------------------------------
`define TMEC_RST_CONTROL   16'h0000
`define TMEC_RST_COMPARE   16'h0000
`define TMEC_RST_COUNT     16'h0000
`define TMEC_CNT_LOAD      16'hffff
`define TMEC_CNT_ZERO      16'h0000
`define TMEC_PRE_LOAD      8'hff

`endif

// ### rtl/tmec_timer.v
// timer channel: pulse-width, period and event counting with gate input
`timescale 1ns/1ps
`include "tmec_map.vh"

// Functional notes
// - mode 100 measures how long the gate stays asserted
// - measurement needs software_run, prescaler enable and gate_enable; running shown
// - first falling counter clock edge loads all ones, later edges decrement
// - pulse mode: gate negation flags, stops and freezes; restarts only after the channel is disarmed
// - reload values unused; counter always reloads all ones
// - gate_level shows the gate level two synchroniser stages late
// - mode 101 measures from one gate assertion to the next
// - period mode: first negation ignored, second assertion flags and stops
// - mode 110 counts falling counter clock edges as events
// - event mode without gate_enable ignores the gate entirely
// - event mode with gate_enable: negation pauses and flags, assertion resumes
// - count equal to compare sets compare_state and compare_flag
// - count reaching zero sets timeout_flag, clears compare_state unless compare is zero, then reloads
// - timer_output toggles at timeout per output_control; output_level shows it
// - counter wraps over 16 bits; prescaler taps readable as low extension
// - gate_event_flag cleared only by writing a one to it
// - enabled flags raise the interrupt request

module tmec_timer (
   // clock and reset
   input  wire        clk,
   input  wire        rstn,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // pins
   input  wire        gate_input_n,
   input  wire        counter_clock_input,
   output reg         timer_output,
   output reg         timer_output_oe,
   // interrupt request
   output reg         irq
);

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_WAIT = 5'h02;
   localparam [4:0] ST_RUN  = 5'h04;
   localparam [4:0] ST_HOLD = 5'h08;
   localparam [4:0] ST_DONE = 5'h10;

   reg  [15:0] control_word_q;
   reg  [15:0] compare_q;
   reg  [15:0] count_q;
   reg  [15:0] count_d;
   reg  [7:0]  pre_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg         load_pend_q;
   reg         load_pend_d;
   reg         seen_neg_q;
   reg         seen_neg_d;
   reg         timeout_flag_q;
   reg         gate_event_flag_q;
   reg         compare_flag_q;
   reg         compare_state_q;
   reg         gate_evt_set;
   reg         out_q;
   reg  [2:0]  gate_sync_q;
   reg  [2:0]  cclk_sync_q;
   reg         tap_q;

   // ----------------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------------
   wire       software_run             = control_word_q[`TMEC_CW_RUN];
   wire       counter_prescaler_enable = control_word_q[`TMEC_CW_CPE];
   wire       gate_enable              = control_word_q[`TMEC_CW_GATE_EN];
   wire       ext_clk_sel              = control_word_q[`TMEC_CW_EXT_CLK];
   wire [2:0] interrupt_select =
              control_word_q[`TMEC_CW_IE_HI:`TMEC_CW_IE_LO];
   wire [2:0] tap_sel = control_word_q[`TMEC_CW_TAP_HI:`TMEC_CW_TAP_LO];
   wire [2:0] mode_select =
              control_word_q[`TMEC_CW_MODE_HI:`TMEC_CW_MODE_LO];
   wire [1:0] output_control =
              control_word_q[`TMEC_CW_OC_HI:`TMEC_CW_OC_LO];

   wire mode_pulse  = (mode_select == `TMEC_MODE_PULSE);
   wire mode_period = (mode_select == `TMEC_MODE_PERIOD);
   wire mode_event  = (mode_select == `TMEC_MODE_EVENT);
   wire armed       = software_run & counter_prescaler_enable &
                      (mode_event | ((mode_pulse | mode_period) &
                                     gate_enable));

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   // stage 0 is only ever read by stage 1; edges come from stages 1 and 2
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gate_sync_q <= 3'h7;
         cclk_sync_q <= 3'h7;
      end else begin
         gate_sync_q <= {gate_sync_q[1:0], gate_input_n};
         cclk_sync_q <= {cclk_sync_q[1:0], counter_clock_input};
      end
   end

   wire gate_level = gate_sync_q[1];
   wire gate_on    = ~gate_sync_q[1];
   wire gate_rise  = ~gate_sync_q[1] & gate_sync_q[2];
   wire gate_fall  = gate_sync_q[1] & ~gate_sync_q[2];
   wire ext_fall   = ~cclk_sync_q[1] & cclk_sync_q[2];

   // ----------------------------------------------------------------------
   // prescaler and counter clock select
   // ----------------------------------------------------------------------
   // the prescaler counts down while the channel runs, so its value is
   // the natural low-order extension of the down counter
   wire running  = (state_q == ST_RUN);
   wire tap_now  = pre_q[tap_sel];
   wire int_fall = tap_q & ~tap_now;
   wire cnt_fall = running & (ext_clk_sel ? ext_fall : int_fall);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_q <= `TMEC_PRE_LOAD;
         tap_q <= 1'b1;
      end else begin
         if (!armed) begin
            pre_q <= `TMEC_PRE_LOAD;
         end else if (running) begin
            pre_q <= pre_q - 8'h01;
         end
         tap_q <= tap_now;
      end
   end

   // ----------------------------------------------------------------------
   // channel control
   // ----------------------------------------------------------------------
   always @* begin
      state_d      = state_q;
      load_pend_d  = load_pend_q;
      seen_neg_d   = seen_neg_q;
      gate_evt_set = 1'b0;
      case (state_q)
         ST_IDLE: begin
            seen_neg_d = 1'b0;
            if (armed) begin
               load_pend_d = 1'b1;
               if (mode_event && !gate_enable) begin
                  state_d = ST_RUN;
               end else if (gate_on) begin
                  state_d = ST_RUN;
               end else begin
                  state_d = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (gate_on) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (mode_pulse && !gate_on) begin
               state_d      = ST_DONE;
               gate_evt_set = 1'b1;
            end else if (mode_period) begin
               if (gate_fall) begin
                  seen_neg_d = 1'b1;
               end
               if (gate_rise && seen_neg_q) begin
                  state_d      = ST_DONE;
                  gate_evt_set = 1'b1;
               end
            end else if (mode_event && gate_enable && !gate_on) begin
               state_d      = ST_HOLD;
               gate_evt_set = 1'b1;
            end
         end
         ST_HOLD: begin
            if (gate_on || !gate_enable) begin
               state_d = ST_RUN;
            end
         end
         ST_DONE: begin
            state_d = ST_DONE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (!armed) begin
         state_d = ST_IDLE;
      end
      if (cnt_fall) begin
         load_pend_d = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q     <= ST_IDLE;
         load_pend_q <= 1'b0;
         seen_neg_q  <= 1'b0;
      end else begin
         state_q     <= state_d;
         load_pend_q <= load_pend_d;
         seen_neg_q  <= seen_neg_d;
      end
   end

   // ----------------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------------
   // reload values are never consulted here: every load is all ones
   always @* begin
      count_d = count_q;
      if (cnt_fall) begin
         if (load_pend_q || count_q == `TMEC_CNT_ZERO) begin
            count_d = `TMEC_CNT_LOAD;
         end else begin
            count_d = count_q - 16'h0001;
         end
      end
   end

   wire hit_zero    = cnt_fall & (count_d == `TMEC_CNT_ZERO);
   wire hit_compare = cnt_fall & (count_d == compare_q);

   // ----------------------------------------------------------------------
   // register writes and flags
   // ----------------------------------------------------------------------
   wire wr_ctrl = reg_wr & (reg_addr == `TMEC_OFS_CONTROL);
   wire wr_stat = reg_wr & (reg_addr == `TMEC_OFS_STATUS);
   wire wr_comp = reg_wr & (reg_addr == `TMEC_OFS_COMPARE);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         control_word_q    <= `TMEC_RST_CONTROL;
         compare_q         <= `TMEC_RST_COMPARE;
         count_q           <= `TMEC_RST_COUNT;
         timeout_flag_q    <= 1'b0;
         gate_event_flag_q <= 1'b0;
         compare_flag_q    <= 1'b0;
         compare_state_q   <= 1'b0;
      end else begin
         count_q <= count_d;
         if (wr_ctrl) begin
            control_word_q <= reg_wdata;
         end
         if (wr_comp) begin
            compare_q <= reg_wdata;
         end
         // a set in the same cycle as a clear wins
         if (hit_zero) begin
            timeout_flag_q <= 1'b1;
         end else if (wr_stat && reg_wdata[`TMEC_SW_TIMEOUT]) begin
            timeout_flag_q <= 1'b0;
         end
         if (gate_evt_set) begin
            gate_event_flag_q <= 1'b1;
         end else if (wr_stat && reg_wdata[`TMEC_SW_GATE_EVT]) begin
            gate_event_flag_q <= 1'b0;
         end
         if (hit_compare) begin
            compare_flag_q <= 1'b1;
         end else if (wr_stat && reg_wdata[`TMEC_SW_COMPARE]) begin
            compare_flag_q <= 1'b0;
         end
         if (hit_compare) begin
            compare_state_q <= 1'b1;
         end else if (hit_zero) begin
            compare_state_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // timer output pin
   // ----------------------------------------------------------------------
   // the pin is released while output_control is off; the level is kept
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_q           <= 1'b0;
         timer_output_oe <= 1'b0;
      end else begin
         timer_output_oe <= (output_control != `TMEC_OC_OFF);
         case (output_control)
            `TMEC_OC_TOGGLE: begin
               if (hit_zero) begin
                  out_q <= ~out_q;
               end
            end
            `TMEC_OC_LOW: begin
               out_q <= 1'b0;
            end
            `TMEC_OC_HIGH: begin
               out_q <= 1'b1;
            end
            default: begin
               out_q <= out_q;
            end
         endcase
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer_output <= 1'b0;
      end else begin
         timer_output <= out_q;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------------
   wire irq_d = (interrupt_select[`TMEC_IE_COMPARE] & compare_flag_q) |
                (interrupt_select[`TMEC_IE_GATE]    & gate_event_flag_q) |
                (interrupt_select[`TMEC_IE_TIMEOUT] & timeout_flag_q);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

   // ----------------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------------
   wire [15:0] status_word = {irq, timeout_flag_q, gate_event_flag_q,
                              compare_flag_q, gate_level, running,
                              timer_output, compare_state_q,
                              pre_q};

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TMEC_OFS_CONTROL: reg_rdata <= control_word_q;
            `TMEC_OFS_STATUS:  reg_rdata <= status_word;
            `TMEC_OFS_COUNT:   reg_rdata <= count_q;
            `TMEC_OFS_COMPARE: reg_rdata <= compare_q;
            default:           reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // tmec_timer
